/* File: trd_pkg.sv */
// trd_pkg: constants for the transceiver reset distribution block.
// assumes one 125 MHz core clock and synchronous, active-high reset.
package trd_pkg;

	// ----------------------------------------
	// sub-block indices into the control vector
	// ----------------------------------------
	localparam int SB_TX_PHASE_FIFO  = 0;
	localparam int SB_TX_ENCODER     = 1;
	localparam int SB_TX_SERIALIZER  = 2;
	localparam int SB_TX_ANALOG      = 3;
	localparam int SB_TX_PLL         = 4;
	localparam int SB_TX_LANE_SM     = 5;
	localparam int SB_SELF_TEST_GEN  = 6;
	localparam int SB_RX_DESERIALIZER = 7;
	localparam int SB_RX_WORD_ALIGN  = 8;
	localparam int SB_RX_DESKEW      = 9;
	localparam int SB_RX_RATE_MATCH  = 10;
	localparam int SB_RX_DECODER     = 11;
	localparam int SB_RX_PHASE_FIFO  = 12;
	localparam int SB_RX_PLL_CRU     = 13;
	localparam int SB_RX_LANE_SM     = 14;
	localparam int SB_SELF_TEST_CHK  = 15;
	localparam int SB_RX_ANALOG      = 16;
	localparam int NUM_SUB           = 17;

	// ----------------------------------------
	// reach of each control over the sub-blocks
	// ----------------------------------------
	localparam logic [16:0] MASK_RX_DIGITAL = 17'h0df00;
	localparam logic [16:0] MASK_RX_ANALOG  = 17'h12080;
	localparam logic [16:0] MASK_TX_DIGITAL = 17'h00063;
	localparam logic [16:0] MASK_ALL        = 17'h1ffff;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [16:0] RST_HOLD  = 17'h1ffff;
	localparam logic        RST_STATE = 1'h0;

	// ----------------------------------------
	// cycles a sub-block reset stays high once its cause is gone
	// ----------------------------------------
	localparam int RELEASE_NS     = 16;
	localparam int CLK_PERIOD_NS  = 8;
	localparam int RELEASE_CYCLES = (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		TRD_OFF,
		TRD_DISABLED,
		TRD_ACTIVE
	} trd_state_t;

endpackage

/* File: trd_release.sv */
// trd_release: holds one sub-block reset high for a fixed number of cycles
// after its request falls. assumes a synchronous request on core_clk_i.
`timescale 1ns/1ps
module trd_release (
	input  wire logic core_clk_i,   // core clock
	input  wire logic reset_i,      // synchronous reset, active high
	input  wire logic req_i,        // reset request for this sub-block
	output logic      rst_o         // registered reset to the sub-block
);
	logic [3:0] cnt_r;

	// request asserts at once; release waits out the counter so the
	// sub-block's own clock domain sees a full reset pulse
	always_ff @(posedge core_clk_i) begin
		if (reset_i || req_i) begin
			cnt_r <= 4'(trd_pkg::RELEASE_CYCLES);
		end else if (cnt_r != 4'h0) begin
			cnt_r <= cnt_r - 4'h1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i || req_i) begin
			rst_o <= 1'h1;
		end else begin
			rst_o <= (cnt_r > 4'h1);
		end
	end
endmodule

/* File: trd_top.sv */
// trd_top: distributes the per-channel transceiver reset and power-down
// controls to the transmit, receive, PLL, lane state machine and self-test
// sub-blocks. assumes all controls are synchronous to core_clk_i.
`timescale 1ns/1ps
module trd_top (
	input  wire logic        core_clk_i,          // core clock, 125 MHz
	input  wire logic        reset_i,             // synchronous reset, active high
	input  wire logic        rx_digital_reset_i,  // receiver digital reset
	input  wire logic        rx_analog_reset_i,   // receiver analog reset
	input  wire logic        tx_digital_reset_i,  // transmit digital reset
	input  wire logic        powerdown_i,         // whole-transceiver power-down
	input  wire logic        enable_i,            // transceiver enable
	output logic [16:0]      sub_reset_o,         // per sub-block reset
	output logic [16:0]      sub_powerdown_o,     // per sub-block power-down
	output logic             powered_o,           // transceiver powered and enabled
	output logic             tx_ready_o,          // tx path out of reset
	output logic             rx_ready_o           // rx path out of reset
);
	// ----------------------------------------
	// global state
	// ----------------------------------------
	trd_pkg::trd_state_t state_r;
	trd_pkg::trd_state_t state_nxt;

	always_comb begin
		case (state_r)
			trd_pkg::TRD_OFF,
			trd_pkg::TRD_DISABLED,
			trd_pkg::TRD_ACTIVE: begin
				if (powerdown_i) begin
					state_nxt = trd_pkg::TRD_OFF;
				end else if (!enable_i) begin
					state_nxt = trd_pkg::TRD_DISABLED;
				end else begin
					state_nxt = trd_pkg::TRD_ACTIVE;
				end
			end
			default: begin
				state_nxt = trd_pkg::TRD_OFF;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			state_r <= trd_pkg::TRD_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------
	// request vector per sub-block
	// ----------------------------------------
	// tx and rx requests are independent; global controls are or-ed over all
	logic [16:0] req_vec;
	logic        global_hold;

	assign global_hold = powerdown_i || !enable_i;

	always_comb begin
		if (global_hold) begin
			req_vec = trd_pkg::MASK_ALL;
		end else begin
			req_vec = ({17{rx_digital_reset_i}} & trd_pkg::MASK_RX_DIGITAL)
			        | ({17{rx_analog_reset_i}}  & trd_pkg::MASK_RX_ANALOG)
			        | ({17{tx_digital_reset_i}} & trd_pkg::MASK_TX_DIGITAL);
		end
	end

	// ----------------------------------------
	// per sub-block reset stretch
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < trd_pkg::NUM_SUB; gi++) begin : g_sub
			trd_release u_release (
				.core_clk_i (core_clk_i),
				.reset_i    (reset_i),
				.req_i      (req_vec[gi]),
				.rst_o      (sub_reset_o[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// power-down and status
	// ----------------------------------------
	// power-down gates analog supply too, so it is not stretched; disable only
	// holds blocks in reset and leaves them powered
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			sub_powerdown_o <= trd_pkg::RST_HOLD;
		end else begin
			sub_powerdown_o <= {17{powerdown_i}} & trd_pkg::MASK_ALL;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			powered_o <= trd_pkg::RST_STATE;
		end else begin
			powered_o <= (state_nxt == trd_pkg::TRD_ACTIVE);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			tx_ready_o <= trd_pkg::RST_STATE;
			rx_ready_o <= trd_pkg::RST_STATE;
		end else begin
			tx_ready_o <= (state_r == trd_pkg::TRD_ACTIVE) && !global_hold
			           && ((sub_reset_o & trd_pkg::MASK_TX_DIGITAL) == 17'h00000)
			           && !tx_digital_reset_i;
			rx_ready_o <= (state_r == trd_pkg::TRD_ACTIVE) && !global_hold
			           && ((sub_reset_o & (trd_pkg::MASK_RX_DIGITAL | trd_pkg::MASK_RX_ANALOG)) == 17'h00000)
			           && !rx_digital_reset_i && !rx_analog_reset_i;
		end
	end
endmodule

/* File: trd_chk.sv */
// trd_chk: port checks for trd_top.
// assumes a bind onto trd_top; one clock, sync reset.
`timescale 1ns/1ps
module trd_chk (
	input wire logic        core_clk_i,         // clock
	input wire logic        reset_i,            // sync reset
	input wire logic        rx_digital_reset_i, // rx digital
	input wire logic        rx_analog_reset_i,  // rx analog
	input wire logic        tx_digital_reset_i, // tx digital
	input wire logic        powerdown_i,        // power-down
	input wire logic        enable_i,           // enable
	input wire logic [16:0] sub_reset_o,        // resets
	input wire logic [16:0] sub_powerdown_o,    // power-downs
	input wire logic        powered_o,          // powered
	input wire logic        tx_ready_o,         // tx path ready
	input wire logic        rx_ready_o          // rx path ready
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	// age keeps the release check off the reset stretch
	logic [1:0] age_r;
	wire logic  quiet = !rx_digital_reset_i && !rx_analog_reset_i && !tx_digital_reset_i && !powerdown_i && enable_i;
	always_ff @(posedge core_clk_i) begin
		age_r <= reset_i ? 2'h0 : (age_r == 2'h3 ? age_r : age_r + 2'h1);
	end
	sequence idle2_s;
		(age_r == 2'h3 && quiet) ##1 quiet;
	endsequence
	sequence rxd_drop_s;
		rx_digital_reset_i ##1 !rx_digital_reset_i;
	endsequence
	rxd_reach_a: assert property (rx_digital_reset_i |=> (sub_reset_o & trd_pkg::MASK_RX_DIGITAL) == trd_pkg::MASK_RX_DIGITAL) else $error("rx digital reach");
	rxa_reach_a: assert property (rx_analog_reset_i |=> (sub_reset_o & trd_pkg::MASK_RX_ANALOG) == trd_pkg::MASK_RX_ANALOG) else $error("rx analog reach");
	txd_reach_a: assert property (tx_digital_reset_i |=> (sub_reset_o & trd_pkg::MASK_TX_DIGITAL) == trd_pkg::MASK_TX_DIGITAL) else $error("tx digital reach");
	rxd_stretch_a: assert property (rxd_drop_s |=> (sub_reset_o & trd_pkg::MASK_RX_DIGITAL) == trd_pkg::MASK_RX_DIGITAL) else $error("release stretch");
	idle_clear_a: assert property (idle2_s |=> sub_reset_o == 17'h0) else $error("resets stuck");
	pd_all_a: assert property (powerdown_i |=> &sub_reset_o && &sub_powerdown_o) else $error("power-down reach");
	pd_follow_a: assert property (!powerdown_i |=> sub_powerdown_o == 17'h0) else $error("power-down stuck");
	en_hold_a: assert property (!enable_i |=> &sub_reset_o && !powered_o) else $error("disable hold");
	pd_over_a: assert property (powerdown_i |=> !powered_o) else $error("power-down override");
	powered_a: assert property (!powerdown_i && enable_i |=> powered_o) else $error("not powered");
	txr_drop_a: assert property (tx_digital_reset_i |=> !tx_ready_o) else $error("tx ready in reset");
	rxr_drop_a: assert property (rx_digital_reset_i || rx_analog_reset_i |=> !rx_ready_o) else $error("rx ready in reset");
endmodule

/* File: trd_ctl.sv */
// trd_ctl: core-logic side driving the transceiver controls.
// assumes the bench picks a pattern on mode_i each cycle.
`timescale 1ns/1ps
module trd_ctl (
	input  wire logic       core_clk_i, // clock
	input  wire logic [4:0] mode_i,     // {en, pd, tx, rx analog, rx digital}
	output logic            rxd_o,      // rx digital reset
	output logic            rxa_o,      // rx analog reset
	output logic            txd_o,      // tx digital reset
	output logic            pd_o,       // power-down
	output logic            en_o        // enable
);
	initial {en_o, pd_o, txd_o, rxa_o, rxd_o} = 5'h10;
	// separate levels so tx and rx move apart; mode is taken at the edge, so the
	// bench may change it just after the edge without a race
	always @(posedge core_clk_i) {en_o, pd_o, txd_o, rxa_o, rxd_o} <= #1 mode_i;
endmodule

/* File: trd_tb_top.sv */
// trd_tb_top: bench for trd_top against a level model.
// assumes trd_ctl drives the controls from mode.
`timescale 1ns/1ps
module trd_tb_top;
	logic        clk = 0, rst = 1, p, e, r;
	logic [4:0]  mode = 5'h10;
	logic [16:0] req, prev = '1, prev2 = '1;
	logic [4:0]  tbl [14] = '{5'h11, 5'h10, 5'h12, 5'h10, 5'h14, 5'h15, 5'h10, 5'h18, 5'h1f, 5'h10, 5'h00, 5'h07,
		5'h13, 5'h10};
	// reach of each control, built from the sub-block indices rather than the design's masks
	localparam logic [16:0] M_RXD = 17'((1 << trd_pkg::SB_RX_WORD_ALIGN) | (1 << trd_pkg::SB_RX_DESKEW)
		| (1 << trd_pkg::SB_RX_RATE_MATCH) | (1 << trd_pkg::SB_RX_DECODER) | (1 << trd_pkg::SB_RX_PHASE_FIFO)
		| (1 << trd_pkg::SB_RX_LANE_SM) | (1 << trd_pkg::SB_SELF_TEST_CHK));
	localparam logic [16:0] M_RXA = 17'((1 << trd_pkg::SB_RX_DESERIALIZER) | (1 << trd_pkg::SB_RX_PLL_CRU)
		| (1 << trd_pkg::SB_RX_ANALOG));
	localparam logic [16:0] M_TXD = 17'((1 << trd_pkg::SB_TX_PHASE_FIFO) | (1 << trd_pkg::SB_TX_ENCODER)
		| (1 << trd_pkg::SB_TX_LANE_SM) | (1 << trd_pkg::SB_SELF_TEST_GEN));
	wire logic   rxd, rxa, txd, pd, en, pwr, txr, rxr;
	wire logic [16:0] srst, spd;
	int fails = 0, cmp_count = 0;
	trd_ctl u_ctl (.core_clk_i(clk), .mode_i(mode), .rxd_o(rxd), .rxa_o(rxa), .txd_o(txd), .pd_o(pd), .en_o(en));
	trd_top u_dut (.core_clk_i(clk), .reset_i(rst), .rx_digital_reset_i(rxd), .rx_analog_reset_i(rxa),
		.tx_digital_reset_i(txd), .powerdown_i(pd), .enable_i(en), .sub_reset_o(srst), .sub_powerdown_o(spd),
		.powered_o(pwr), .tx_ready_o(txr), .rx_ready_o(rxr));
	task automatic chk_vec(string n, logic [16:0] x, logic [16:0] g);
		cmp_count++;
		if (g !== x) begin
			fails++;
			$display("FAIL %s exp %h got %h", n, x, g);
		end
	endtask
	task automatic chk_bit(string n, logic x, logic g);
		chk_vec(n, {16'h0, x}, {16'h0, g});
	endtask
	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ----------------
	// reference model
	// ----------------
	initial forever #4 clk = ~clk;
	always @(posedge clk) begin
		{p, e, r} = {pd, en, rst};
		req = (rxd ? M_RXD : 17'h0) | (rxa ? M_RXA : 17'h0)
			| (txd ? M_TXD : 17'h0) | ((p || !e || r) ? 17'h1ffff : 17'h0);
		#1;
		chk_vec("sub_reset", req | prev, srst);
		chk_vec("sub_powerdown", (p || r) ? 17'h1ffff : 17'h0, spd);
		chk_bit("powered", !r && !p && e, pwr);
		chk_bit("tx_ready", ((req | prev | prev2) & M_TXD) == 17'h0, txr);
		chk_bit("rx_ready", ((req | prev | prev2) & (M_RXD | M_RXA)) == 17'h0, rxr);
		prev2 = prev;
		prev = req;
	end
	initial begin
		void'($urandom(38));
		repeat (10) @(posedge clk);
		#1 rst = 0;
		foreach (tbl[i]) begin
			mode = tbl[i];
			repeat (3) @(posedge clk);
			#1;
		end
		repeat (2) begin
			repeat (200) begin
				mode = 5'($urandom);
				@(posedge clk);
				#1;
			end
			rst = 1;
			repeat (2) @(posedge clk);
			#1 rst = 0;
		end
		close_out;
	end
	initial begin
		#10000;
		fails++;
		close_out;
	end
endmodule
bind trd_top trd_chk u_chk (.*);
